//--- hw/srs_top.sv
// gate sequencer for a secondary-side synchronous rectifier driver
// assumes comparator levels arrive asynchronously from analog pins
`timescale 1ns/1ps
`include "srs_cfg.svh"

// How it works
// - sync at zero after a first negative pulse drives both gates high
// - positive sync pulse holds gate a low while it lasts
// - negative sync pulse holds gate b low while it lasts
// - a wrong pulse sequence forces both gates low
// - every sync edge either way starts a timer reset
// - timer threshold crossing forces both gates low
// - gate a trip is ignored during blanking after gate a rises
// - after blanking a gate a trip pulls gate a low
// - gate b trip is ignored during blanking after gate b rises
// - after blanking a gate b trip pulls gate b low
// - undervoltage holds both gates low
// - return to zero after a positive pulse raises gate a again
// - with pulses stopped at zero both gates stay on until a fault
// - two same-polarity pulses lock gates low until opposite polarity
// - timer reset is a fixed width pulse on each sync edge
// - both comparators at once count as a positive pulse for sequencing but hold both gates low
module srs_top
  import srs_pkg::*;
(
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // comparator inputs
  input  srs_pkg::srs_cmp_t i_cmp,
  // gate drive and timer discharge
  output srs_pkg::srs_gates_t o_gates,
  output logic            o_timer_reset
);
  import srs_pkg::*;

  // three-stage synchronisers; a change counts when stages 2 and 3 agree
  srs_cmp_t s1_reg;
  srs_cmp_t s2_reg;
  srs_cmp_t s3_reg;
  srs_cmp_t cmp_reg;
  srs_cmp_t cmp_next;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      cmp_reg <= '0;
    end else begin
      s1_reg  <= i_cmp;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      cmp_reg <= cmp_next;
    end
  end

  // bitwise: keep old value where the two stages disagree
  assign cmp_next = srs_cmp_t'((s2_reg & s3_reg)
                    | (cmp_reg & (s2_reg ^ s3_reg)));

  // sync level classification
  wire logic pos_lvl  = cmp_reg.sync_pos;
  wire logic neg_lvl  = cmp_reg.sync_neg;
  wire logic zero_lvl = !pos_lvl && !neg_lvl;

  // pulse polarity latched during the pulse
  srs_pol_t   cur_pol_reg;
  srs_pol_t   cur_pol_next;
  srs_pol_t   last_pol_reg;
  srs_pol_t   last_pol_next;
  srs_state_t state_reg;
  srs_state_t state_next;
  logic       in_pulse_reg;
  logic       in_pulse_next;

  // pulse start: either sync comparator leaves zero
  wire logic pulse_start = !in_pulse_reg && !zero_lvl;
  wire logic pulse_end   = in_pulse_reg && zero_lvl;
  // both comparators tripping is taken as positive polarity
  wire srs_pol_t start_pol = pos_lvl ? SRS_POL_POS : SRS_POL_NEG;
  wire logic repeat_pol = pulse_start && (start_pol == last_pol_reg);

  assign in_pulse_next = pulse_start ? 1'b1 :
                         pulse_end ? 1'b0 : in_pulse_reg;
  assign cur_pol_next  = pulse_start ? start_pol :
                         pulse_end ? SRS_POL_NONE : cur_pol_reg;
  assign last_pol_next = pulse_start ? start_pol : last_pol_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SRS_ST_IDLE: begin
        // run only once the first negative pulse has fully passed
        if (pulse_end && cur_pol_reg == SRS_POL_NEG) begin
          state_next = SRS_ST_RUN;
        end
      end
      SRS_ST_RUN: begin
        if (repeat_pol) begin
          state_next = SRS_ST_LOCK;
        end
      end
      SRS_ST_LOCK: begin
        if (pulse_start && !repeat_pol) begin
          state_next = SRS_ST_RUN;
        end
      end
      default: begin
        state_next = SRS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg    <= SRS_ST_IDLE;
      cur_pol_reg  <= SRS_POL_NONE;
      last_pol_reg <= SRS_POL_NONE;
      in_pulse_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cur_pol_reg  <= cur_pol_next;
      last_pol_reg <= last_pol_next;
      in_pulse_reg <= in_pulse_next;
    end
  end

  // timer reset pulse on every sync edge
  logic       sync_act_reg;
  logic [`SRS_CNT_W-1:0] trst_cnt_reg;
  logic [`SRS_CNT_W-1:0] trst_cnt_next;
  logic       trst_reg;
  wire logic sync_act   = !zero_lvl;
  wire logic sync_edge  = sync_act ^ sync_act_reg;
  wire logic trst_busy  = (trst_cnt_reg != `SRS_CNT_ZERO);

  assign trst_cnt_next = sync_edge ? `SRS_CNT_W'(`SRS_TMR_RST_CYC) :
                         trst_busy ? trst_cnt_reg - `SRS_CNT_W'(1) :
                         trst_cnt_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync_act_reg <= 1'b0;
      trst_cnt_reg <= `SRS_CNT_ZERO;
      trst_reg     <= 1'b0;
    end else begin
      sync_act_reg <= sync_act;
      trst_cnt_reg <= trst_cnt_next;
      trst_reg     <= (trst_cnt_next != `SRS_CNT_ZERO);
    end
  end

  // gate decisions
  logic gate_a_reg;
  logic gate_b_reg;
  logic trip_a_lat_reg;
  logic trip_b_lat_reg;
  wire logic trip_a_ok;
  wire logic trip_b_ok;

  srs_blank u_blank_a (
    .i_sys_clk    (i_sys_clk),
    .i_rst        (i_rst),
    .i_gate_on    (gate_a_reg),
    .i_trip       (cmp_reg.trip_a),
    .o_trip_valid (trip_a_ok)
  );

  srs_blank u_blank_b (
    .i_sys_clk    (i_sys_clk),
    .i_rst        (i_rst),
    .i_gate_on    (gate_b_reg),
    .i_trip       (cmp_reg.trip_b),
    .o_trip_valid (trip_b_ok)
  );

  // global kill: undervoltage, timeout, bad sequence, not yet started
  wire logic kill = cmp_reg.uvlo
                 || cmp_reg.timeout
                 || (state_reg != SRS_ST_RUN)
                 || (state_next != SRS_ST_RUN);
  // hold each channel's trip until the next sync pulse rearms it
  // a trip seen in the cycle of a pulse start still latches: set wins
  wire logic trip_a_next = trip_a_ok || (trip_a_lat_reg && !pulse_start);
  wire logic trip_b_next = trip_b_ok || (trip_b_lat_reg && !pulse_start);
  // both on at zero; pulse polarity turns one off
  wire logic gate_a_next = !kill
                        && (zero_lvl
                        || neg_lvl && !pos_lvl)
                        && !trip_a_next;
  wire logic gate_b_next = !kill && (zero_lvl || pos_lvl && !neg_lvl)
                        && !trip_b_next;
  // positive pulse keeps a low, negative pulse keeps b low
  wire logic a_low_pulse = pos_lvl;
  wire logic b_low_pulse = neg_lvl;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      gate_a_reg     <= 1'b0;
      gate_b_reg     <= 1'b0;
      trip_a_lat_reg <= 1'b0;
      trip_b_lat_reg <= 1'b0;
    end else begin
      gate_a_reg     <= gate_a_next && !a_low_pulse;
      gate_b_reg     <= gate_b_next && !b_low_pulse;
      trip_a_lat_reg <= trip_a_next;
      trip_b_lat_reg <= trip_b_next;
    end
  end

  assign o_gates.gate_drive_a = gate_a_reg;
  assign o_gates.gate_drive_b = gate_b_reg;
  assign o_timer_reset        = trst_reg;
endmodule

//--- hw/srs_cfg.svh
// constants for the synchronous rectifier gate sequencer
// assumes a 25 MHz system clock; times are in ns
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH

`define SRS_CLK_PERIOD_NS  40
`define SRS_BLANK_NS       250
`define SRS_TMR_RST_NS     200
// least times round up to whole cycles
`define SRS_BLANK_CYC  ((`SRS_BLANK_NS + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_TMR_RST_CYC ((`SRS_TMR_RST_NS + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_CNT_W          4
`define SRS_CNT_ZERO       4'h0

`endif

//--- hw/srs_pkg.sv
// types for the synchronous rectifier gate sequencer
// shared by the top module, the checker and the testbench
package srs_pkg;

  typedef enum logic [1:0] {
    SRS_POL_NONE,
    SRS_POL_POS,
    SRS_POL_NEG
  } srs_pol_t;

  typedef enum logic [1:0] {
    SRS_ST_IDLE,
    SRS_ST_RUN,
    SRS_ST_LOCK
  } srs_state_t;

  // comparator levels from the analog front end
  typedef struct packed {
    logic sync_pos;
    logic sync_neg;
    logic timeout;
    logic uvlo;
    logic trip_a;
    logic trip_b;
  } srs_cmp_t;

  typedef struct packed {
    logic gate_drive_a;
    logic gate_drive_b;
  } srs_gates_t;

endpackage

//--- hw/srs_blank.sv
// blanking counter for one channel's reverse-current trip
// assumes the gate enable comes from a register in the same clock domain
`timescale 1ns/1ps
`include "srs_cfg.svh"
module srs_blank (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // channel
  input  wire logic i_gate_on,
  input  wire logic i_trip,
  output logic      o_trip_valid
);
  logic [`SRS_CNT_W-1:0] cnt_reg;
  logic [`SRS_CNT_W-1:0] cnt_next;
  wire logic blanked = (cnt_reg < `SRS_CNT_W'(`SRS_BLANK_CYC));

  assign cnt_next = !i_gate_on ? `SRS_CNT_ZERO :
                    blanked ? cnt_reg + `SRS_CNT_W'(1) : cnt_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_reg <= `SRS_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // trip counts only once the gate has been high long enough
  assign o_trip_valid = i_gate_on && !blanked && i_trip;
endmodule

//--- tb/srs_checker.sv
// assertions on the gate sequencer ports
// assumes one clock domain and a bind onto srs_top
`timescale 1ns/1ps
module srs_checker
  import srs_pkg::*;
(
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst,
  input  srs_pkg::srs_cmp_t   i_cmp,
  input  srs_pkg::srs_gates_t o_gates,
  input  wire logic           o_timer_reset
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_quiet;
    !i_cmp.sync_pos && !i_cmp.sync_neg && !i_cmp.uvlo && !i_cmp.timeout;
  endsequence
  sequence s_a_rise;
    $rose(o_gates.gate_drive_a) ##1 s_quiet[*6];
  endsequence
  uvlo_gates_a: assert property (i_cmp.uvlo[*8] |-> o_gates == 2'h0)
    else $error("gates on under undervoltage");
  tmo_gates_a: assert property (i_cmp.timeout[*8] |-> o_gates == 2'h0)
    else $error("gates on after timeout");
  rst_idle_a: assert property ($fell(i_rst) |-> o_gates == 2'h0)
    else $error("gates on after reset");
  tmr_width_a: assert property ($rose(o_timer_reset) |-> o_timer_reset[*5])
    else $error("timer reset pulse too short");
  sync_tmr_a: assert property ($changed(i_cmp.sync_pos) |-> ##[1:8] o_timer_reset)
    else $error("no timer reset after sync edge");
  pos_gate_a: assert property (i_cmp.sync_pos[*8] |-> !o_gates.gate_drive_a)
    else $error("gate a on during positive pulse");
  neg_gate_a: assert property (i_cmp.sync_neg[*8] |-> !o_gates.gate_drive_b)
    else $error("gate b on during negative pulse");
  blank_hold_a: assert property (s_a_rise |-> o_gates.gate_drive_a)
    else $error("gate a cut inside blanking");
  trip_cut_a: assert property ((o_gates.gate_drive_a && i_cmp.trip_a)[*8]
    |-> ##[0:6] !o_gates.gate_drive_a) else $error("gate a trip ignored");
  trip_cut_b_a: assert property ((o_gates.gate_drive_b && i_cmp.trip_b)[*8]
    |-> ##[0:6] !o_gates.gate_drive_b) else $error("gate b trip ignored");
endmodule
bind srs_top srs_checker srs_checker_i (
  .i_sys_clk    (i_sys_clk),
  .i_rst        (i_rst),
  .i_cmp        (i_cmp),
  .o_gates      (o_gates),
  .o_timer_reset(o_timer_reset)
);

//--- tb/srs_primary_model.sv
// primary controller as seen through the sync transformer
// assumes level inputs; one sync output low makes a pulse
`timescale 1ns/1ps
module srs_primary_model (
  // primary sync outputs
  input  wire logic i_primary_sync_out_a,
  input  wire logic i_primary_sync_out_b,
  // comparator levels
  output logic      o_sync_pos,
  output logic      o_sync_neg
);
  assign o_sync_pos = !i_primary_sync_out_a && i_primary_sync_out_b;
  assign o_sync_neg = i_primary_sync_out_a && !i_primary_sync_out_b;
endmodule

//--- tb/tb_srs_top.sv
// testbench for the gate sequencer
// assumes 25 MHz clock and the primary model on the sync inputs
`timescale 1ns/1ps
`include "srs_cfg.svh"
module tb_srs_top;
  import srs_pkg::*;
  logic       i_sys_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       sa = 1'b1;
  logic       sb = 1'b1;
  logic       tmo = 1'b0;
  logic       uv = 1'b0;
  logic       ta = 1'b0;
  logic       tb = 1'b0;
  logic       pos;
  logic       neg;
  logic       tmr;
  srs_cmp_t   cmp;
  srs_gates_t gates;
  int         n_fail = 0;
  int         num_checks = 0;
  assign cmp = {pos, neg, tmo, uv, ta, tb};
  always #20 i_sys_clk = ~i_sys_clk;
  srs_primary_model srs_primary_model_i (
    .i_primary_sync_out_a(sa),
    .i_primary_sync_out_b(sb),
    .o_sync_pos          (pos),
    .o_sync_neg          (neg)
  );
  srs_top srs_top_i (
    .i_sys_clk    (i_sys_clk),
    .i_rst        (i_rst),
    .i_cmp        (cmp),
    .o_gates      (gates),
    .o_timer_reset(tmr)
  );
  task automatic wt(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic bad(input string m);
    n_fail++;
    $display("mismatch at %0t %s", $time, m);
  endtask
  task automatic chk(input srs_gates_t e);
    num_checks++;
    if (gates !== e) bad("gate levels wrong");
  endtask
  // set both primary sync outputs and let the block settle
  task automatic drv(input logic a, input logic b, input srs_gates_t e);
    sa = a;
    sb = b;
    wt(16);
    chk(e);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_start();
    drv(1'b0, 1'b1, 2'h0);
    drv(1'b1, 1'b1, 2'h0);
  endtask
  task automatic t_cycle();
    int hi;
    hi = 0;
    drv(1'b1, 1'b0, 2'h0);
    drv(1'b1, 1'b1, 2'h3);
    drv(1'b0, 1'b1, 2'h1);
    drv(1'b1, 1'b1, 2'h3);
    sb = 1'b0;
    repeat (16) begin
      wt(1);
      if (tmr === 1'b1) hi++;
    end
    num_checks++;
    if (hi != `SRS_TMR_RST_CYC) bad("timer reset width");
    chk(2'h2);
    drv(1'b1, 1'b1, 2'h3);
    wt(200);
    chk(2'h3);
  endtask
  task automatic t_double();
    drv(1'b0, 1'b1, 2'h1);
    drv(1'b1, 1'b1, 2'h3);
    drv(1'b0, 1'b1, 2'h0);
    drv(1'b1, 1'b1, 2'h0);
    drv(1'b1, 1'b0, 2'h2);
    drv(1'b1, 1'b1, 2'h3);
  endtask
  task automatic t_trip();
    ta = 1'b1;
    wt(16);
    chk(2'h1);
    ta = 1'b0;
    tb = 1'b1;
    wt(16);
    chk(2'h0);
    tb = 1'b0;
    sa = 1'b0;
    wt(16);
    // trip already pending when gate a rises: blanking must hold it off
    ta = 1'b1;
    sa = 1'b1;
    wt(8);
    chk(2'h3);
    wt(8);
    chk(2'h1);
    ta = 1'b0;
  endtask
  task automatic t_fault();
    uv = 1'b1;
    wt(16);
    chk(2'h0);
    uv = 1'b0;
    sb = 1'b0;
    wt(16);
    // trip already pending when gate b rises
    tb = 1'b1;
    sb = 1'b1;
    wt(8);
    chk(2'h3);
    wt(8);
    chk(2'h2);
    tb = 1'b0;
    drv(1'b0, 1'b1, 2'h1);
    drv(1'b1, 1'b1, 2'h3);
    tmo = 1'b1;
    wt(16);
    chk(2'h0);
    tmo = 1'b0;
  endtask
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    bad("run hung");
    complete_run();
  end
  initial begin
    wt(8);
    i_rst = 1'b0;
    wt(2);
    chk(2'h0);
    t_start();
    t_cycle();
    t_double();
    t_trip();
    t_fault();
    complete_run();
  end
endmodule
